// ### rtl/rt_table_pkg.sv
// constants shared by the data-table manager and its bench.
// assumes a 16-bit shared RAM of 8K words and a classic wishbone host.
package rt_table_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_PTR_BASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // config register fields
  localparam int CFG_SEP_BROADCAST = 0;
  localparam int CFG_LEGACY = 1;
  localparam int CFG_TAG_SELECT = 2;
  localparam int CFG_PULSE_CTRL = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [12:0] PTR_BASE_RESET = 13'h0000;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_MSG_ERR = 1;
  localparam int ST_SSF = 2;
  localparam int ST_IDX_LSB = 8;

  // ==========================================================
  // pointer-table indices
  localparam logic [6:0] IDX_TX_BASE = 7'h20;
  localparam logic [6:0] IDX_MODE_BASE = 7'h40;
  localparam logic [6:0] IDX_BROADCAST_BASE = 7'h60;
  localparam logic [6:0] IDX_BROADCAST_SA31 = 7'h7F;
  localparam logic [4:0] SA_MODE_LOW = 5'h00;
  localparam logic [4:0] SA_MODE_HIGH = 5'h1F;

  // defined mode codes: 0-8 and 16-21
  localparam logic [31:0] MODE_DEFINED = 32'h003F_01FF;

  // ==========================================================
  // command word fields
  localparam int CMD_TR = 10;
  localparam int CMD_SA_LSB = 5;

  // tag word fields
  localparam int TAG_FRESH = 15;
  localparam int TAG_SSF_EN = 14;
  localparam int TAG_BROADCAST = 13;
  localparam int TAG_PULSE_LSB = 8;
  localparam int TAG_LOCK = 7;
  localparam int TAG_INVALID = 6;
  localparam int TAG_STALE = 5;
  localparam logic [3:0] PULSE_CMD_CODE = 4'hE;

  // pointer word fields
  localparam int PTR_IRQ_REQ = 15;
  localparam int PTR_TT_HI = 14;
  localparam int PTR_TT_LO = 0;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;

endpackage

// ### rtl/rt_data_table_manager.sv
// remote-terminal data-table manager: maps commands to pointer-table
// slots, runs the locked tag handshake and moves message data words.
// assumes a same-clock bus front end and a shared-RAM arbiter that
// answers each request with a one-cycle ack after at least one cycle.
//
// How it works
// - index from t/r and subaddress: rx 1-30, tx 33-62, mode 64-95
// - config bit 0 moves broadcast receive to indices 97-127
// - legacy option makes subaddress 31 an ordinary subaddress
// - zero pointer address: illegal command, error status, no data moved
// - undefined mode codes are ignored entirely
// - tag-select config bit decides if first table word is a tag word
// - tag bit 15 marks the table freshly updated
// - tag bit 14 lets stale transmit or overwrite raise subsystem flag
// - tag bit 13 records whether data came from a broadcast
// - tag bits 11:8 choose a discrete pulse or the pulse-command pin
// - tag bit 7 held high while the table is in use
// - tag bit 6 marks table contents invalid
// - tag bit 5 flags overwrite of unread data or stale transmit
// - command count field is copied into tag bits 4:0
// - pointer bit 15 requests header push and interrupt at message end when msg_ok_i is set
// - pointer bits 13:1 give the table word address in lowest 8K
// - pointer bits 14,0 select time tagging and tag transmission
// - fetch pointer, lock, transfer, unlock and update fresh bit
// - untouched table at access start sets the overrun bit
// - pointer read to tag write back is locked against the host
`timescale 1ns/1ns

module rt_data_table_manager
  import rt_table_pkg::*;
#(
  parameter int PULSE_LEN = rt_table_pkg::PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // shared ram master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [12:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic mem_lock_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  // command from the bus front end
  input wire logic cmd_valid_i,
  input wire logic [15:0] cmd_word_i,
  input wire logic cmd_broadcast_i,
  input wire logic [31:0] time_tag_i,
  output logic cmd_done_o,
  output logic message_error_flag_o,
  output logic subsystem_flag_o,
  output logic cmd_ignored_o,
  // data words
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_data_i,
  output logic rx_ready_o,
  input wire logic tx_req_i,
  output logic tx_valid_o,
  output logic [15:0] tx_data_o,
  input wire logic msg_end_i,
  input wire logic msg_ok_i,
  // completion events
  output logic hdr_push_o,
  output logic [15:0] hdr_o,
  output logic table_interrupt_request_o,
  output logic [7:0] io_pulse_o,
  output logic pulse_command_pin_o,
  output logic busy_o
);

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_PTR = 4'b0001,
    S_TAG = 4'b0010,
    S_LOCK = 4'b0011,
    S_TTH = 4'b0100,
    S_TTL = 4'b0101,
    S_DATA = 4'b0110,
    S_RXWR = 4'b0111,
    S_TXRD = 4'b1000,
    S_END = 4'b1001,
    S_FIN = 4'b1010
  } phase_type;

  typedef struct packed {
    phase_type st;
    logic [3:0] cfg;
    logic [12:0] base;
    logic [6:0] idx;
    logic [15:0] cmd;
    logic bcast;
    logic [15:0] ptr;
    logic [15:0] tag;
    logic stale;
    logic ok;
    logic [12:0] widx;
    logic [1:0] tt_sent;
    logic [31:0] ttime;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic mem_req;
    logic mem_we;
    logic [12:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_lock;
    logic done;
    logic msg_err;
    logic ssf;
    logic ign;
    logic rx_ready;
    logic tx_valid;
    logic [15:0] tx_data;
    logic hdr_push;
    logic irq;
    logic [7:0] io_pulse;
    logic pulse_cmd;
    logic [15:0] pulse_cnt;
    logic busy;
  } state_type;

  state_type q, d;

  // ==========================================================
  // helpers
  function automatic logic is_mode(input logic [15:0] c, input logic leg);
    logic [4:0] sa;
    sa = c[CMD_SA_LSB +: 5];
    is_mode = (sa == SA_MODE_LOW) || (sa == SA_MODE_HIGH && !leg);
  endfunction

  function automatic logic [6:0] table_index(input logic [15:0] c,
      input logic b, input logic sep, input logic leg);
    logic [6:0] sa;
    sa = {2'b00, c[CMD_SA_LSB +: 5]};
    if (is_mode(c, leg))
      table_index = IDX_MODE_BASE + {2'b00, c[4:0]};
    else if (c[CMD_TR])
      table_index = IDX_TX_BASE + sa;
    else if (b && sep)
      table_index = (sa == {2'b00, SA_MODE_HIGH}) ? IDX_BROADCAST_SA31 :
                    IDX_BROADCAST_BASE + sa;
    else
      table_index = sa;
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    logic tag_on;
    logic tr;
    logic [6:0] ix;
    tag_on = !q.cfg[CFG_TAG_SELECT];
    tr = q.cmd[CMD_TR];
    ix = table_index(cmd_word_i, cmd_broadcast_i, q.cfg[CFG_SEP_BROADCAST],
                     q.cfg[CFG_LEGACY]);
    d = q;
    d.done = 1'b0;
    d.tx_valid = 1'b0;
    d.hdr_push = 1'b0;
    d.irq = 1'b0;
    // register slave: answers every address, unmapped reads zero
    d.wb_ack = wb_cyc_i && wb_stb_i && !q.wb_ack;
    d.wb_dat = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !q.wb_ack) begin
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CONFIG)
        d.cfg = wb_dat_i[3:0];
      if (wb_we_i && wb_adr_i == REG_PTR_BASE) begin
        if (wb_sel_i[0])
          d.base[7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1])
          d.base[12:8] = wb_dat_i[12:8];
      end
      case (wb_adr_i)
        REG_CONFIG: d.wb_dat = {28'h000_0000, q.cfg};
        REG_PTR_BASE: d.wb_dat = {19'h0_0000, q.base};
        REG_STATUS: begin
          d.wb_dat[ST_BUSY] = q.st != S_IDLE;
          d.wb_dat[ST_MSG_ERR] = q.msg_err;
          d.wb_dat[ST_SSF] = q.ssf;
          d.wb_dat[ST_IDX_LSB +: 7] = q.idx;
        end
        default: d.wb_dat = 32'h0000_0000;
      endcase
    end
    // pulse stretcher for discrete outputs
    if (q.pulse_cnt != 16'h0000)
      d.pulse_cnt = q.pulse_cnt - 16'h0001;
    else begin
      d.io_pulse = 8'h00;
      d.pulse_cmd = 1'b0;
    end
    // a request is dropped in the cycle after its ack
    if (q.mem_req && mem_ack_i)
      d.mem_req = 1'b0;
    case (q.st)
      S_IDLE: begin
        if (cmd_valid_i) begin
          d.cmd = cmd_word_i;
          d.bcast = cmd_broadcast_i;
          d.ttime = time_tag_i;
          d.idx = ix;
          d.tt_sent = 2'b00;
          d.msg_err = 1'b0;
          d.ssf = 1'b0;
          d.ign = 1'b0;
          if (is_mode(cmd_word_i, q.cfg[CFG_LEGACY]) &&
              !MODE_DEFINED[cmd_word_i[4:0]]) begin
            d.ign = 1'b1;
            d.done = 1'b1;
          end else begin
            d.mem_req = 1'b1;
            d.mem_we = 1'b0;
            d.mem_addr = q.base + {6'h00, ix};
            d.mem_lock = 1'b1;
            d.st = S_PTR;
          end
        end
      end
      S_PTR: begin
        if (mem_ack_i) begin
          d.ptr = mem_rdata_i;
          if (mem_rdata_i[13:1] == 13'h0000) begin
            d.msg_err = 1'b1;
            d.done = 1'b1;
            d.mem_lock = 1'b0;
            d.st = S_IDLE;
          end else if (tag_on) begin
            d.mem_req = 1'b1;
            d.mem_addr = mem_rdata_i[13:1];
            d.st = S_TAG;
          end else begin
            d.mem_lock = 1'b0;
            d.widx = mem_rdata_i[13:1];
            d.stale = 1'b0;
            d.st = S_LOCK;
          end
        end
      end
      S_TAG: begin
        if (mem_ack_i) begin
          d.tag = mem_rdata_i;
          d.stale = tr ? !mem_rdata_i[TAG_FRESH] :
                    mem_rdata_i[TAG_FRESH];
          d.ssf = mem_rdata_i[TAG_SSF_EN] &&
                  (tr ? !mem_rdata_i[TAG_FRESH] :
                   mem_rdata_i[TAG_FRESH]);
          d.mem_req = 1'b1;
          d.mem_we = 1'b1;
          d.mem_wdata = mem_rdata_i;
          d.mem_wdata[TAG_LOCK] = 1'b1;
          d.widx = q.mem_addr + 13'h0001;
          d.st = S_LOCK;
        end
      end
      S_LOCK: begin
        // time tag words sit right after the tag word
        if (!tag_on || mem_ack_i) begin
          d.mem_lock = 1'b0;
          if (q.ptr[PTR_TT_HI]) begin
            d.mem_req = 1'b1;
            d.mem_we = 1'b1;
            d.mem_addr = q.widx;
            d.mem_wdata = q.ttime[31:16];
            d.st = S_TTH;
          end else begin
            d.done = 1'b1;
            d.rx_ready = !tr;
            d.st = S_DATA;
          end
        end
      end
      S_TTH: begin
        if (mem_ack_i) begin
          d.mem_req = 1'b1;
          d.mem_addr = q.widx + 13'h0001;
          d.mem_wdata = q.ttime[15:0];
          d.st = S_TTL;
        end
      end
      S_TTL: begin
        if (mem_ack_i) begin
          d.widx = q.widx + 13'h0002;
          d.done = 1'b1;
          d.rx_ready = !tr;
          d.st = S_DATA;
        end
      end
      S_DATA: begin
        if (msg_end_i) begin
          d.ok = msg_ok_i;
          d.rx_ready = 1'b0;
          if (tag_on) begin
            d.mem_req = 1'b1;
            d.mem_we = 1'b1;
            d.mem_addr = q.ptr[13:1];
            d.mem_wdata = q.tag;
            d.mem_wdata[TAG_FRESH] = !tr;
            d.mem_wdata[TAG_BROADCAST] = q.bcast && msg_ok_i && !tr;
            d.mem_wdata[TAG_LOCK] = 1'b0;
            d.mem_wdata[TAG_INVALID] = !msg_ok_i;
            d.mem_wdata[TAG_STALE] = q.tag[TAG_STALE] || q.stale;
            d.mem_wdata[4:0] = q.cmd[4:0];
            d.st = S_END;
          end else
            d.st = S_FIN;
        end else if (!tr && rx_valid_i && q.rx_ready) begin
          d.rx_ready = 1'b0;
          d.mem_req = 1'b1;
          d.mem_we = 1'b1;
          d.mem_addr = q.widx;
          d.mem_wdata = rx_data_i;
          d.st = S_RXWR;
        end else if (tr && tx_req_i) begin
          if (q.ptr[PTR_TT_HI] && q.ptr[PTR_TT_LO] &&
              q.tt_sent != 2'b10) begin
            // tag goes out first, high word first
            d.tx_valid = 1'b1;
            d.tx_data = (q.tt_sent == 2'b00) ? q.ttime[31:16] :
                        q.ttime[15:0];
            d.tt_sent = q.tt_sent + 2'b01;
          end else begin
            d.mem_req = 1'b1;
            d.mem_we = 1'b0;
            d.mem_addr = q.widx;
            d.st = S_TXRD;
          end
        end
      end
      S_RXWR: begin
        if (mem_ack_i) begin
          d.widx = q.widx + 13'h0001;
          d.rx_ready = 1'b1;
          d.st = S_DATA;
        end
      end
      S_TXRD: begin
        if (mem_ack_i) begin
          d.tx_valid = 1'b1;
          d.tx_data = mem_rdata_i;
          d.widx = q.widx + 13'h0001;
          d.st = S_DATA;
        end
      end
      S_END: begin
        if (mem_ack_i)
          d.st = S_FIN;
      end
      S_FIN: begin
        d.st = S_IDLE;
        if (q.ok) begin
          if (tag_on && q.cfg[CFG_PULSE_CTRL]) begin
            if (q.tag[TAG_PULSE_LSB +: 4] >= 4'h1 &&
                q.tag[TAG_PULSE_LSB +: 4] <= 4'h8) begin
              d.io_pulse = 8'h01 << (q.tag[TAG_PULSE_LSB +: 4] - 4'h1);
              d.pulse_cmd = 1'b0; // a new pulse cuts any older one short
              d.pulse_cnt = 16'(PULSE_LEN - 1);
            end else if (q.tag[TAG_PULSE_LSB +: 4] == PULSE_CMD_CODE) begin
              d.pulse_cmd = 1'b1;
              d.io_pulse = 8'h00;
              d.pulse_cnt = 16'(PULSE_LEN - 1);
            end
          end
          if (q.ptr[PTR_IRQ_REQ]) begin
            d.hdr_push = 1'b1;
            d.irq = 1'b1;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
    // busy kept as its own flop so the pin is a bare register
    d.busy = d.st != S_IDLE;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= S_IDLE;
      q.cfg <= CFG_RESET;
      q.base <= PTR_BASE_RESET;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign wb_dat_o = q.wb_dat;
  assign wb_ack_o = q.wb_ack;
  assign mem_req_o = q.mem_req;
  assign mem_we_o = q.mem_we;
  assign mem_addr_o = q.mem_addr;
  assign mem_wdata_o = q.mem_wdata;
  assign mem_lock_o = q.mem_lock;
  assign cmd_done_o = q.done;
  assign message_error_flag_o = q.msg_err;
  assign subsystem_flag_o = q.ssf;
  assign cmd_ignored_o = q.ign;
  assign rx_ready_o = q.rx_ready;
  assign tx_valid_o = q.tx_valid;
  assign tx_data_o = q.tx_data;
  assign hdr_push_o = q.hdr_push;
  assign hdr_o = q.cmd;
  assign table_interrupt_request_o = q.irq;
  assign io_pulse_o = q.io_pulse;
  assign pulse_command_pin_o = q.pulse_cmd;
  assign busy_o = q.busy;

endmodule // rt_data_table_manager

// ### verif/rt_table_checker.sv
// port assertions for the data-table manager.
// assumes it is bound onto rt_data_table_manager, single clock.
`timescale 1ns/1ns
module rt_table_checker #(
  parameter int PULSE_LEN = rt_table_pkg::PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // ram master
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [12:0] mem_addr_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic mem_lock_o,
  input wire logic mem_ack_i,
  // command and data
  input wire logic cmd_valid_i,
  input wire logic cmd_done_o,
  input wire logic message_error_flag_o,
  input wire logic cmd_ignored_o,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire logic busy_o,
  // completion events
  input wire logic hdr_push_o,
  input wire logic table_interrupt_request_o,
  input wire logic [7:0] io_pulse_o,
  input wire logic pulse_command_pin_o
);
  // ==========================================================
  // pulse width counter, too long for a repetition
  logic any_p;
  logic [7:0] cnt_q;
  assign any_p = (|io_pulse_o) | pulse_command_pin_o;
  always_ff @(posedge clk_i) begin
    if (rst_i || !any_p) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("register access not acked");
  chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
    && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("ram request changed before ack");
  chk_lock_release: assert property (
    $fell(mem_lock_o) |-> $past(mem_ack_i))
    else $error("lock dropped inside a ram access");
  chk_lock_done: assert property (cmd_done_o |-> !mem_lock_o)
    else $error("lock still held at status");
  chk_hdr_irq: assert property (
    hdr_push_o || table_interrupt_request_o
    |-> hdr_push_o && table_interrupt_request_o)
    else $error("header push and interrupt apart");
  chk_pulse_len: assert property ($fell(any_p)
    |-> cnt_q == PULSE_LEN) else $error("pulse width wrong");
  chk_pulse_one: assert property (
    $onehot0({io_pulse_o, pulse_command_pin_o}))
    else $error("more than one pulse output");
  chk_no_data: assert property (
    cmd_done_o && (message_error_flag_o || cmd_ignored_o)
    |-> (!rx_ready_o && !tx_valid_o)[*4])
    else $error("data phase after refused command");
  chk_done_bound: assert property (
    cmd_valid_i && !busy_o |=> ##[0:60] cmd_done_o)
    else $error("no status after command");
  chk_lock_tag: assert property (
    mem_req_o && mem_we_o && mem_lock_o |-> mem_wdata_o[7])
    else $error("locked tag write without lock bit");

  // main scenarios
  cover property (hdr_push_o);
  cover property (cmd_done_o && message_error_flag_o);
  cover property (cmd_done_o && cmd_ignored_o);
  cover property (pulse_command_pin_o);
endmodule // rt_table_checker

bind rt_data_table_manager rt_table_checker #(.PULSE_LEN(PULSE_LEN))
  rt_table_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_lock_o,
  .mem_ack_i, .cmd_valid_i, .cmd_done_o, .message_error_flag_o,
  .cmd_ignored_o, .rx_ready_o, .tx_valid_o, .busy_o, .hdr_push_o,
  .table_interrupt_request_o, .io_pulse_o, .pulse_command_pin_o);

// ### verif/rt_ram_model.sv
// shared ram and arbiter model for the table manager bench.
// assumes one clock; answers after one or three cycles.
`timescale 1ns/1ns
module rt_ram_model (
  // clock, reset, pacing
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  // ram port from the manager
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [12:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o
);
  // all tables live in the lowest 8K words
  logic [15:0] mem [0:8191];
  logic [1:0] wait_q;
  initial begin
    mem_rdata_o = 16'h0000;
    for (int i = 0; i < 8192; i++) mem[i] = 16'h0000;
  end
  // one request at a time; read data toggles when not valid
  always @(posedge clk_i) begin
    mem_ack_o <= 1'h0;
    mem_rdata_o <= ~mem_rdata_o;
    if (rst_i) begin
      wait_q <= 2'h0;
    end else if (mem_req_i && !mem_ack_o) begin
      if (wait_q >= {slow_i, 1'h0}) begin
        mem_ack_o <= 1'h1;
        wait_q <= 2'h0;
        mem_rdata_o <= mem[mem_addr_i];
        if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule // rt_ram_model

// ### verif/rt_data_table_manager_bench.sv
// self-checking bench for the data-table manager.
// assumes the ram model stands in for the shared ram and arbiter.
`timescale 1ns/1ns
module rt_data_table_manager_bench;
  import rt_table_pkg::*;
  localparam int PL = 3;
  logic clk_i = 1'h0, rst_i = 1'h1, slow = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic mem_req_o, mem_we_o, mem_lock_o, mem_ack_i;
  logic [12:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic cmd_valid_i = 1'h0, cmd_broadcast_i = 1'h0, cmd_done_o;
  logic [15:0] cmd_word_i = 16'h0, rx_data_i = 16'h0, tx_data_o, hdr_o;
  logic [31:0] time_tag_i = 32'h1234_5678;
  logic message_error_flag_o, subsystem_flag_o, cmd_ignored_o;
  logic rx_valid_i = 1'h0, tx_req_i = 1'h0, msg_end_i = 1'h0;
  logic msg_ok_i = 1'h1, rx_ready_o, tx_valid_o, busy_o;
  logic hdr_push_o, table_interrupt_request_o, pulse_command_pin_o;
  logic [7:0] io_pulse_o, p_io;
  logic p_cmd, fe, fs, fi;
  logic [15:0] hdr_seen, txw [0:3];
  int hdr_n = 0, bad_count = 0, n_compared = 0;

  rt_data_table_manager #(.PULSE_LEN(PL)) rt_data_table_manager_i (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_lock_o, .mem_ack_i, .mem_rdata_i,
    .cmd_valid_i, .cmd_word_i, .cmd_broadcast_i, .time_tag_i, .cmd_done_o,
    .message_error_flag_o, .subsystem_flag_o, .cmd_ignored_o,
    .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_req_i, .tx_valid_o,
    .tx_data_o, .msg_end_i, .msg_ok_i, .hdr_push_o, .hdr_o,
    .table_interrupt_request_o, .io_pulse_o, .pulse_command_pin_o,
    .busy_o);
  rt_ram_model rt_ram_model_i (.clk_i, .rst_i, .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  always #5 clk_i = ~clk_i;
  // event capture on the falling edge, apart from task clears
  always @(negedge clk_i) begin
    p_io = p_io | io_pulse_o;
    p_cmd = p_cmd | pulse_command_pin_o;
    if (hdr_push_o) begin
      hdr_n++;
      hdr_seen = hdr_o;
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // bounded wait for a level sampled at a rising edge
  task automatic waitfor(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (s !== v && n < 80);
    if (s !== v) chk(32'h0, 32'h1);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    waitfor(wb_ack_o, 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // one whole message: command, status, words, end
  task automatic run(input logic [15:0] c, input logic b, input int nrx,
                     input int ntx);
    p_io = 8'h00;
    p_cmd = 1'h0;
    @(posedge clk_i);
    cmd_valid_i <= 1'h1;
    cmd_word_i <= c;
    cmd_broadcast_i <= b;
    // one-cycle offer: an idle design would take a held command twice
    @(posedge clk_i);
    cmd_valid_i <= 1'h0;
    waitfor(cmd_done_o, 1'h1);
    fe = message_error_flag_o;
    fs = subsystem_flag_o;
    fi = cmd_ignored_o;
    if (!(fe | fi)) begin
      for (int i = 0; i < nrx; i++) begin
        rx_valid_i <= 1'h1;
        rx_data_i <= 16'hA000 + 16'(i);
        waitfor(rx_ready_o, 1'h1);
      end
      rx_valid_i <= 1'h0;
      if (nrx > 0) waitfor(rx_ready_o, 1'h1);
      for (int i = 0; i < ntx; i++) begin
        tx_req_i <= 1'h1;
        @(posedge clk_i);
        tx_req_i <= 1'h0;
        waitfor(tx_valid_o, 1'h1);
        txw[i] = tx_data_o;
      end
      msg_end_i <= 1'h1;
      @(posedge clk_i);
      msg_end_i <= 1'h0;
    end
    waitfor(busy_o, 1'h0);
    repeat (PL + 4) @(posedge clk_i);
  endtask

  initial begin
    #200000;
    bad_count++;
    finish_test;
  end

  // ==========================================================
  // tests
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, REG_CONFIG, 32'h0);
    chk(rd, 32'h0);
    wb(1'h0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    wb(1'h1, REG_PTR_BASE, 32'h10);
    wb(1'h0, REG_PTR_BASE, 32'h0);
    chk(rd, 32'h10);
    $display("test registers done");
    rt_ram_model_i.mem[16'h13] = 16'h8200;
    rt_ram_model_i.mem[16'h100] = 16'h4100;
    run(16'h0062, 1'h0, 2, 0);
    chk(rt_ram_model_i.mem[16'h100][7], 1'h0);
    chk(rt_ram_model_i.mem[16'h100], 16'hC102);
    chk(rt_ram_model_i.mem[16'h102], 16'hA001);
    chk({fs, p_io}, 9'h000);
    chk({hdr_n, hdr_seen}, {32'd1, 16'h0062});
    slow <= 1'h1;
    wb(1'h1, REG_CONFIG, 32'h8);
    run(16'h0062, 1'h0, 2, 0);
    chk(rt_ram_model_i.mem[16'h100], 16'hC122);
    chk({fs, p_io}, 9'h101);
    $display("test receive done");
    rt_ram_model_i.mem[16'h33] = 16'h4401;
    rt_ram_model_i.mem[16'h200] = 16'h8E00;
    rt_ram_model_i.mem[16'h203] = 16'h5555;
    run(16'h0462, 1'h0, 0, 3);
    chk({txw[0], txw[1], txw[2]}, 48'h1234_5678_5555);
    chk(rt_ram_model_i.mem[16'h202], 16'h5678);
    chk(rt_ram_model_i.mem[16'h200], 16'h0E02);
    chk({p_cmd, hdr_n}, {1'h1, 32'd2});
    $display("test transmit done");
    rt_ram_model_i.mem[16'h52] = 16'h0C00;
    msg_ok_i <= 1'h0;
    run(16'h07E2, 1'h0, 0, 0);
    msg_ok_i <= 1'h1;
    chk(rt_ram_model_i.mem[16'h600], 16'h0062);
    rt_ram_model_i.mem[16'h59] = 16'h0A00;
    rt_ram_model_i.mem[16'h500] = 16'h1234;
    run(16'h0009, 1'h0, 0, 0);
    chk({fi, fe, rt_ram_model_i.mem[16'h500]}, 18'h21234);
    run(16'h00A1, 1'h0, 1, 0);
    chk(fe, 1'h1);
    wb(1'h0, REG_STATUS, 32'h0);
    chk(rd, 32'h0000_0502);
    $display("test mode and illegal done");
    wb(1'h1, REG_CONFIG, 32'h6);
    rt_ram_model_i.mem[16'h2F] = 16'h0800;
    run(16'h03E1, 1'h0, 1, 0);
    chk(rt_ram_model_i.mem[16'h400], 16'hA000);
    wb(1'h1, REG_CONFIG, 32'h1);
    rt_ram_model_i.mem[16'h72] = 16'h0600;
    run(16'h0041, 1'h1, 1, 0);
    chk(rt_ram_model_i.mem[16'h300], 16'hA001);
    $display("test options done");
    finish_test;
  end
endmodule // rt_data_table_manager_bench
